/* File: hw/emo_pkg.sv */
// Shared types and constants for the extended-operand execute datapath
package emo_pkg;

  // Datapath sizes
  localparam int unsigned EMO_DATA_W      = 8;       // Data memory byte width
  localparam int unsigned EMO_ADDR_W      = 16;      // Default flat data address width
  localparam int unsigned EMO_BIT_W       = 3;       // Bit selector width

  // APB register byte offsets
  localparam logic [7:0]  EMO_OFS_WREG    = 8'h00;   // Working register
  localparam logic [7:0]  EMO_OFS_FLAGS   = 8'h04;   // Arithmetic flags
  localparam logic [7:0]  EMO_OFS_STATUS  = 8'h08;   // Execute status, read only

  // Reset values
  localparam logic [7:0]  EMO_WREG_RST    = 8'h00;   // Working register after reset
  localparam logic [5:0]  EMO_FLAGS_RST   = 6'h00;   // All flags clear after reset

  // Flag field positions in the flags register
  localparam int unsigned EMO_FLG_BORROW  = 0;       // Borrow-out flag
  localparam int unsigned EMO_FLG_ZERO    = 1;       // Zero flag
  localparam int unsigned EMO_FLG_HALF    = 2;       // Half borrow flag
  localparam int unsigned EMO_FLG_WRAP    = 3;       // Signed wrap flag
  localparam int unsigned EMO_FLG_SIGN    = 4;       // Signed result flag
  localparam int unsigned EMO_FLG_MBNULL  = 5;       // Multi-byte null flag

  // Status field positions
  localparam int unsigned EMO_ST_BUSY     = 0;       // Execute in progress
  localparam int unsigned EMO_ST_SKIP     = 1;       // Last instruction took its skip

  // Operations carried out by this datapath
  typedef enum logic [4:0] {
    emo_rotl_mem, emo_rotl_copy_to_w, emo_rotl_thru_borrow, emo_rotl_thru_borrow_to_w,
    emo_rotr_mem, emo_rotr_copy_to_w, emo_rotr_thru_borrow, emo_rotr_thru_borrow_to_w,
    emo_sub_with_borrow, emo_sub_with_borrow_to_mem,
    emo_plain_subtract, emo_plain_subtract_to_mem,
    emo_dec_skip_zero, emo_dec_copy_skip_zero, emo_inc_skip_zero, emo_inc_copy_skip_zero,
    emo_set_byte, emo_set_bit, emo_skip_if_nonzero, emo_skip_if_nonzero_bit,
    emo_skip_if_null, emo_skip_if_null_bit, emo_copy_skip_if_null,
    emo_nibble_exchange, emo_nibble_exchange_to_w
  } emo_op_type;

  // Flags as one packed group, ordered to match the field positions
  typedef struct packed {
    logic mbnull;
    logic sign;
    logic wrap;
    logic half;
    logic zero;
    logic borrow;
  } emo_flags_type;

  // Outcome of one execute cycle
  typedef struct packed {
    logic [7:0]    value;    // Result byte
    logic          to_mem;   // Write result to memory
    logic          to_w;     // Write result to working register
    emo_flags_type flags;    // Flags after the instruction
    logic          skip;     // Next instruction is skipped
  } emo_res_type;

endpackage

/* File: hw/emo_exec.sv */
// Execute datapath for the extended-operand rotate, subtract, set, swap and skip group
//
// What this block does
// - Rotate-left copy puts rotated byte in W
// - Rotate left through borrow, written to memory
// - Same rotate left, result into W instead
// - Rotate right memory byte, flags untouched
// - Rotate-right copy puts rotated byte in W
// - Rotate right through borrow, written to memory
// - Same rotate right, result into W instead
// - Subtract with borrow updates all six flags
// - Subtract with borrow, difference into memory
// - Decrement memory, skip when result zero
// - Decrement into W, skip when zero
// - Taken skip adds one dummy cycle
// - Byte set writes all ones to memory
// - Bit set forces only selected bit
// - Increment memory, skip when it wraps
// - Increment into W, skip when zero
// - Skip when selected bit is one
// - Rewrite byte, skip when nonzero
// - Plain subtract to W or memory
// - Swap nibbles to memory or W
// - Rewrite byte, skip when zero
// - Copy byte to W, skip when zero
// - Full flat address reaches every section
`timescale 1ns/1ps

module emo_exec
  #(
    parameter int unsigned ADDR_W = emo_pkg::EMO_ADDR_W  // Flat data memory address width
  )
  (
    // Clock, reset and freeze
    input  wire logic                   clk_sys_in,
    input  wire logic                   reset_in,
    input  wire logic                   clk_en_in,
    // Sequencer request
    input  wire logic                   req_valid_in,
    input  wire emo_pkg::emo_op_type    req_op_in,
    input  wire logic [2:0]             req_bit_in,
    input  wire logic [ADDR_W-1:0]      req_addr_in,
    output logic                        busy_out,
    output logic                        done_out,
    output logic                        skip_out,
    // Data memory port
    output logic [ADDR_W-1:0]           mem_addr_out,
    output logic                        mem_rd_out,
    input  wire logic [7:0]             mem_rdata_in,
    output logic                        mem_we_out,
    output logic [7:0]                  mem_wdata_out,
    // Core state seen by the rest of the core
    output logic [7:0]                  working_register_out,
    output emo_pkg::emo_flags_type      flags_out,
    // APB slave
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [7:0]             paddr_in,
    input  wire logic [31:0]            pwdata_in,
    input  wire logic [3:0]             pstrb_in,
    output logic                        pready_out,
    output logic [31:0]                 prdata_out,
    output logic                        pslverr_out
  );

  import emo_pkg::*;

  // Refuse address widths that cannot hold a byte address
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("emo_exec: ADDR_W must lie between 8 and 32");
  end

  // Execute sequence states
  typedef enum logic [1:0] {st_idle, st_read, st_dummy} emo_state_type;

  emo_state_type   state_q;         // Sequence state
  emo_op_type      op_q;            // Latched operation
  logic [2:0]      bit_q;           // Latched bit selector
  logic [ADDR_W-1:0] addr_q;        // Latched full operand address
  logic [7:0]      w_q;             // Working register
  emo_flags_type   flags_q;         // Arithmetic flags
  logic            mem_rd_q;        // Memory read strobe
  logic            busy_q;          // Sequence not idle, kept as a flop for the output
  logic            mem_we_q;        // Memory write strobe
  logic [7:0]      mem_wdata_q;     // Memory write data
  logic            done_q;          // Instruction finished pulse
  logic            skip_q;          // Skip taken pulse
  logic            last_skip_q;     // Sticky copy of the last skip decision
  logic            pready_q;        // APB ready
  logic [31:0]     prdata_q;        // APB read data
  logic            pslverr_q;       // APB error
  emo_res_type     res;             // Combinational execute outcome

  // Subtract core shared by both subtract families; nb is the borrow in, the inverted flag for subtract with borrow
  function automatic emo_res_type emo_sub(input logic [7:0] a, input logic [7:0] b,
                                          input logic nb, input emo_flags_type f,
                                          input logic chain);
    emo_res_type r;
    logic [8:0]  d;
    logic [4:0]  h;
    r = '0;
    d = {1'b0, a} - {1'b0, b} - {8'h00, nb};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, nb};
    r.value        = d[7:0];
    r.flags.borrow = ~d[8];                                   // Cleared on negative result
    r.flags.zero   = (d[7:0] == 8'h00);
    r.flags.half   = ~h[4];
    r.flags.wrap   = (a[7] != b[7]) && (d[7] != a[7]);
    r.flags.sign   = d[7] ^ r.flags.wrap;
    // Chained form keeps zero only if every earlier byte was zero too
    r.flags.mbnull = chain ? (r.flags.zero & f.mbnull) : r.flags.zero;
    return r;
  endfunction

  // Combinational outcome of the latched operation on the byte now read
  always_comb
  begin
    res       = '0;
    res.flags = flags_q;
    case (op_q)
      emo_rotl_mem:
      begin
        res.value  = {mem_rdata_in[6:0], mem_rdata_in[7]};
        res.to_mem = 1'b1;
      end
      emo_rotl_copy_to_w:
      begin
        res.value = {mem_rdata_in[6:0], mem_rdata_in[7]};
        res.to_w  = 1'b1;
      end
      emo_rotl_thru_borrow, emo_rotl_thru_borrow_to_w:
      begin
        res.value        = {mem_rdata_in[6:0], flags_q.borrow};
        res.flags.borrow = mem_rdata_in[7];
        res.to_mem       = (op_q == emo_rotl_thru_borrow);
        res.to_w         = (op_q == emo_rotl_thru_borrow_to_w);
      end
      emo_rotr_mem:
      begin
        res.value  = {mem_rdata_in[0], mem_rdata_in[7:1]};
        res.to_mem = 1'b1;
      end
      emo_rotr_copy_to_w:
      begin
        res.value = {mem_rdata_in[0], mem_rdata_in[7:1]};
        res.to_w  = 1'b1;
      end
      emo_rotr_thru_borrow, emo_rotr_thru_borrow_to_w:
      begin
        res.value        = {flags_q.borrow, mem_rdata_in[7:1]};
        res.flags.borrow = mem_rdata_in[0];
        res.to_mem       = (op_q == emo_rotr_thru_borrow);
        res.to_w         = (op_q == emo_rotr_thru_borrow_to_w);
      end
      emo_sub_with_borrow, emo_sub_with_borrow_to_mem:
      begin
        res        = emo_sub(w_q, mem_rdata_in, ~flags_q.borrow, flags_q, 1'b1);
        res.to_w   = (op_q == emo_sub_with_borrow);
        res.to_mem = (op_q == emo_sub_with_borrow_to_mem);
      end
      emo_plain_subtract, emo_plain_subtract_to_mem:
      begin
        res        = emo_sub(w_q, mem_rdata_in, 1'b0, flags_q, 1'b0);
        res.to_w   = (op_q == emo_plain_subtract);
        res.to_mem = (op_q == emo_plain_subtract_to_mem);
      end
      emo_dec_skip_zero, emo_dec_copy_skip_zero:
      begin
        res.value  = mem_rdata_in - 8'h01;
        res.skip   = (res.value == 8'h00);
        res.to_mem = (op_q == emo_dec_skip_zero);
        res.to_w   = (op_q == emo_dec_copy_skip_zero);
      end
      emo_inc_skip_zero, emo_inc_copy_skip_zero:
      begin
        res.value  = mem_rdata_in + 8'h01;
        res.skip   = (res.value == 8'h00);
        res.to_mem = (op_q == emo_inc_skip_zero);
        res.to_w   = (op_q == emo_inc_copy_skip_zero);
      end
      emo_set_byte:
      begin
        res.value  = 8'hff;
        res.to_mem = 1'b1;
      end
      emo_set_bit:
      begin
        res.value  = mem_rdata_in | (8'h01 << bit_q);
        res.to_mem = 1'b1;
      end
      emo_skip_if_nonzero:
      begin
        // The byte is rewritten unchanged, which matters for side-effect locations
        res.value  = mem_rdata_in;
        res.to_mem = 1'b1;
        res.skip   = (mem_rdata_in != 8'h00);
      end
      emo_skip_if_nonzero_bit:
      begin
        res.value = mem_rdata_in;
        res.skip  = mem_rdata_in[bit_q];
      end
      emo_skip_if_null:
      begin
        res.value  = mem_rdata_in;
        res.to_mem = 1'b1;
        res.skip   = (mem_rdata_in == 8'h00);
      end
      emo_skip_if_null_bit:
      begin
        res.value = mem_rdata_in;
        res.skip  = ~mem_rdata_in[bit_q];
      end
      emo_copy_skip_if_null:
      begin
        res.value = mem_rdata_in;
        res.to_w  = 1'b1;
        res.skip  = (mem_rdata_in == 8'h00);
      end
      emo_nibble_exchange, emo_nibble_exchange_to_w:
      begin
        res.value  = {mem_rdata_in[3:0], mem_rdata_in[7:4]};
        res.to_mem = (op_q == emo_nibble_exchange);
        res.to_w   = (op_q == emo_nibble_exchange_to_w);
      end
      default:
      begin
        res.value = mem_rdata_in;
      end
    endcase
  end

  // Sequence: take request, read operand and execute, then a dummy cycle on a skip
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q  <= st_idle;
      op_q     <= emo_rotl_mem;
      busy_q   <= 1'b0;
      bit_q    <= 3'h0;
      addr_q   <= '0;
      mem_rd_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      case (state_q)
        st_idle:
        begin
          if (req_valid_in)
          begin
            // Whole flat address is kept, so no bank limits the reach
            addr_q   <= req_addr_in;
            op_q     <= req_op_in;
            bit_q    <= req_bit_in;
            mem_rd_q <= 1'b1;
            busy_q   <= 1'b1;
            state_q  <= st_read;
          end
        end
        st_read:
        begin
          mem_rd_q <= 1'b0;
          // A taken skip costs one extra cycle while the next fetch is discarded
          state_q  <= res.skip ? st_dummy : st_idle;
          busy_q   <= res.skip;
        end
        st_dummy:
        begin
          state_q <= st_idle;
          busy_q  <= 1'b0;
        end
        default:
        begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // Commit of memory write, working register and flags on the same edge
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      w_q         <= EMO_WREG_RST;
      flags_q     <= emo_flags_type'(EMO_FLAGS_RST);
      mem_we_q    <= 1'b0;
      mem_wdata_q <= 8'h00;
    end
    else if (clk_en_in)
    begin
      mem_we_q <= 1'b0;
      if (state_q == st_read)
      begin
        mem_we_q    <= res.to_mem;
        mem_wdata_q <= res.value;
        flags_q     <= res.flags;
        if (res.to_w)
          w_q <= res.value;
      end
      else if (apb_wr_take(psel_in, penable_in, pwrite_in, pready_q) && state_q == st_idle)
      begin
        // Software writes only land while no instruction is in flight
        if (paddr_in == EMO_OFS_WREG && pstrb_in[0])
          w_q <= pwdata_in[7:0];
        else if (paddr_in == EMO_OFS_FLAGS && pstrb_in[0])
          flags_q <= emo_flags_type'(pwdata_in[5:0]);
      end
    end
  end

  // Done and skip pulses to the sequencer
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      done_q      <= 1'b0;
      skip_q      <= 1'b0;
      last_skip_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      done_q <= (state_q == st_read && !res.skip) || (state_q == st_dummy);
      skip_q <= (state_q == st_read) && res.skip;
      if (state_q == st_read)
        last_skip_q <= res.skip;
    end
  end

  // A write is taken at the ready edge of an access phase
  function automatic logic apb_wr_take(input logic s, input logic e, input logic w,
                                       input logic r);
    return s && e && w && r;
  endfunction

  // APB slave: one wait state, then ready for one cycle with data or error
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (psel_in && penable_in && !pready_q)
      begin
        pready_q  <= 1'b1;
        prdata_q  <= 32'h0000_0000;
        pslverr_q <= 1'b0;
        if (paddr_in == EMO_OFS_WREG)
          prdata_q <= {24'h00_0000, w_q};
        else if (paddr_in == EMO_OFS_FLAGS)
          prdata_q <= {26'h0, flags_q};
        else if (paddr_in == EMO_OFS_STATUS)
        begin
          prdata_q[EMO_ST_BUSY] <= (state_q != st_idle);
          prdata_q[EMO_ST_SKIP] <= last_skip_q;
          pslverr_q             <= pwrite_in;                 // Status is read only
        end
        else
          pslverr_q <= 1'b1;                                  // Unmapped address
      end
      else
      begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Outputs straight from flip-flops
  assign busy_out             = busy_q;
  assign done_out             = done_q;
  assign skip_out             = skip_q;
  assign mem_addr_out         = addr_q;
  assign mem_rd_out           = mem_rd_q;
  assign mem_we_out           = mem_we_q;
  assign mem_wdata_out        = mem_wdata_q;
  assign working_register_out = w_q;
  assign flags_out            = flags_q;
  assign pready_out           = pready_q;
  assign prdata_out           = prdata_q;
  assign pslverr_out          = pslverr_q;

endmodule

/* File: bench/emo_mem_model.sv */
// Behavioural data memory standing behind the execute datapath
`timescale 1ns/1ps

module emo_mem_model
  #(
    parameter int unsigned ADDR_W = 16  // Flat address width
  )
  (
    // Clock
    input  wire logic              clk_sys_in,
    // Memory port
    input  wire logic [ADDR_W-1:0] mem_addr_in,
    input  wire logic              mem_rd_in,
    input  wire logic              mem_we_in,
    input  wire logic [7:0]        mem_wdata_in,
    output logic [7:0]             mem_rdata_out
  );

  logic [7:0] mem [0:(2**ADDR_W)-1];  // Byte store, preset by the bench
  logic [7:0] last_q = 8'h00;         // Last byte handed out

  // Data is only good in the read cycle; elsewhere show the inverse so a late use shows up
  assign mem_rdata_out = mem_rd_in ? mem[mem_addr_in] : ~last_q;

  // Writes land on the edge that samples the write strobe
  always @(posedge clk_sys_in)
  begin
    if (mem_we_in)
      mem[mem_addr_in] <= mem_wdata_in;
    if (mem_rd_in)
      last_q <= mem[mem_addr_in];
  end

endmodule

/* File: bench/emo_exec_chk.sv */
// Port-level assertions for the execute datapath
`timescale 1ns/1ps

module emo_exec_chk
  #(
    parameter int unsigned ADDR_W = 16  // Flat address width
  )
  (
    // Clock and reset
    input wire logic                  clk_sys_in,
    input wire logic                  reset_in,
    // Sequencer side
    input wire logic                  req_valid_in,
    input wire emo_pkg::emo_op_type   req_op_in,
    input wire logic [ADDR_W-1:0]     req_addr_in,
    input wire logic                  busy_out,
    input wire logic                  done_out,
    input wire logic                  skip_out,
    // Memory side
    input wire logic [ADDR_W-1:0]     mem_addr_out,
    input wire logic                  mem_rd_out,
    input wire logic [7:0]            mem_rdata_in,
    input wire logic                  mem_we_out,
    input wire logic [7:0]            mem_wdata_out,
    input wire emo_pkg::emo_flags_type flags_out,
    // APB handshake
    input wire logic                  psel_in,
    input wire logic                  penable_in,
    input wire logic                  pready_out
  );
  import emo_pkg::*;

  logic [7:0] rdata_q;  // Operand byte seen in the read cycle

  // Keep the operand so write data can be tied to it a cycle later
  always_ff @(posedge clk_sys_in)
  begin
    rdata_q <= mem_rdata_in;
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  // A request taken while idle
  sequence s_take;
    !busy_out && req_valid_in;
  endsequence

  // A request of one given operation taken while idle
  sequence s_take_op(emo_op_type op);
    !busy_out && req_valid_in && req_op_in == op;
  endsequence

  property p_fetch;
    s_take |=> mem_rd_out && busy_out && mem_addr_out == $past(req_addr_in);
  endproperty
  a_fetch: assert property (p_fetch) else $error("operand read missing");

  property p_answer;
    mem_rd_out |=> done_out != skip_out;
  endproperty
  a_answer: assert property (p_answer) else $error("no finish after read");

  property p_skip_tail;
    skip_out |=> done_out && !skip_out;
  endproperty
  a_skip_tail: assert property (p_skip_tail) else $error("no dummy cycle");

  property p_set_byte;
    s_take_op(emo_set_byte) |=> ##1 (mem_we_out && mem_wdata_out == 8'hff);
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("byte set wrong");

  property p_dec_skip;
    s_take_op(emo_dec_skip_zero) ##1 (mem_rdata_in == 8'h01)
      |=> skip_out && mem_we_out && mem_wdata_out == 8'h00;
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");

  property p_inc_wrap;
    s_take_op(emo_inc_skip_zero) ##1 1'b1 |=> mem_we_out
      && mem_wdata_out == 8'(rdata_q + 8'h01) && skip_out == (mem_wdata_out == 8'h00);
  endproperty
  a_inc_wrap: assert property (p_inc_wrap) else $error("increment skip wrong");

  property p_swap;
    s_take_op(emo_nibble_exchange) ##1 1'b1
      |=> mem_we_out && mem_wdata_out == {rdata_q[3:0], rdata_q[7:4]};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_flags_kept;
    s_take ##0 !(req_op_in inside {emo_rotl_thru_borrow, emo_rotl_thru_borrow_to_w,
      emo_rotr_thru_borrow, emo_rotr_thru_borrow_to_w, emo_sub_with_borrow,
      emo_sub_with_borrow_to_mem, emo_plain_subtract, emo_plain_subtract_to_mem})
      |=> ##1 $stable(flags_out);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags disturbed");

  property p_copy_no_write;
    s_take ##0 (req_op_in inside {emo_rotl_copy_to_w, emo_rotl_thru_borrow_to_w,
      emo_rotr_copy_to_w, emo_rotr_thru_borrow_to_w, emo_sub_with_borrow,
      emo_plain_subtract, emo_dec_copy_skip_zero, emo_inc_copy_skip_zero,
      emo_copy_skip_if_null, emo_nibble_exchange_to_w}) |=> ##1 !mem_we_out;
  endproperty
  a_copy_no_write: assert property (p_copy_no_write) else $error("memory written");

  property p_apb_wait;
    psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("ready timing wrong");

endmodule

/* File: bench/emo_exec_tb.sv */
// Self-checking testbench for the execute datapath
`timescale 1ns/1ps

module emo_exec_tb;
  import emo_pkg::*;

  // One directed case: start state and expected end state
  typedef struct {
    emo_op_type op;
    logic [2:0] b;
    logic [7:0] m, w;
    logic [5:0] f0;
    logic [7:0] em, ew;
    logic [5:0] ef;
    logic       sk;
  } emo_case_type;

  logic          clk_sys_in, reset_in, req_valid_in, busy_out, done_out, skip_out;
  emo_op_type    req_op_in;
  logic [2:0]    req_bit_in;
  logic [15:0]   req_addr_in, mem_addr_out;
  logic          mem_rd_out, mem_we_out, psel_in, penable_in, pwrite_in;
  logic [7:0]    mem_rdata_in, mem_wdata_out, working_register_out, paddr_in;
  emo_flags_type flags_out;
  logic [31:0]   pwdata_in, prdata_out, rd;
  logic          pready_out, pslverr_out, err;
  int            error_cnt, compares;

  // Flags start patterned (2a/2b) outside the subtract cases so any stray change is seen
  emo_case_type cases [28] = '{
    '{emo_rotl_copy_to_w,3'd0,8'h81,8'h5a,6'h2a,8'h81,8'h03,6'h2a,1'b0},
    '{emo_rotl_thru_borrow,3'd0,8'h81,8'h5a,6'h2a,8'h02,8'h5a,6'h2b,1'b0},
    '{emo_rotl_thru_borrow_to_w,3'd0,8'h40,8'h5a,6'h2b,8'h40,8'h81,6'h2a,1'b0},
    '{emo_rotr_mem,3'd0,8'h01,8'h5a,6'h2a,8'h80,8'h5a,6'h2a,1'b0},
    '{emo_rotr_copy_to_w,3'd0,8'h03,8'h5a,6'h2a,8'h03,8'h81,6'h2a,1'b0},
    '{emo_rotr_thru_borrow,3'd0,8'h01,8'h5a,6'h2a,8'h00,8'h5a,6'h2b,1'b0},
    '{emo_rotr_thru_borrow_to_w,3'd0,8'h02,8'h5a,6'h2b,8'h02,8'h81,6'h2a,1'b0},
    '{emo_sub_with_borrow,3'd0,8'h01,8'h10,6'h01,8'h01,8'h0f,6'h01,1'b0},
    '{emo_sub_with_borrow,3'd0,8'h05,8'h05,6'h21,8'h05,8'h00,6'h27,1'b0},
    '{emo_sub_with_borrow_to_mem,3'd0,8'h00,8'h00,6'h00,8'hff,8'h00,6'h10,1'b0},
    '{emo_dec_skip_zero,3'd0,8'h01,8'h5a,6'h2a,8'h00,8'h5a,6'h2a,1'b1},
    '{emo_dec_skip_zero,3'd0,8'h00,8'h5a,6'h2a,8'hff,8'h5a,6'h2a,1'b0},
    '{emo_dec_copy_skip_zero,3'd0,8'h01,8'h5a,6'h2a,8'h01,8'h00,6'h2a,1'b1},
    '{emo_set_byte,3'd0,8'h12,8'h5a,6'h2a,8'hff,8'h5a,6'h2a,1'b0},
    '{emo_set_bit,3'd5,8'h81,8'h5a,6'h2a,8'ha1,8'h5a,6'h2a,1'b0},
    '{emo_inc_skip_zero,3'd0,8'hff,8'h5a,6'h2a,8'h00,8'h5a,6'h2a,1'b1},
    '{emo_inc_copy_skip_zero,3'd0,8'h7f,8'h5a,6'h2a,8'h7f,8'h80,6'h2a,1'b0},
    '{emo_skip_if_nonzero_bit,3'd7,8'h80,8'h5a,6'h2a,8'h80,8'h5a,6'h2a,1'b1},
    '{emo_skip_if_nonzero_bit,3'd0,8'hfe,8'h5a,6'h2a,8'hfe,8'h5a,6'h2a,1'b0},
    '{emo_skip_if_nonzero,3'd0,8'h01,8'h5a,6'h2a,8'h01,8'h5a,6'h2a,1'b1},
    '{emo_plain_subtract,3'd0,8'h01,8'h80,6'h00,8'h01,8'h7f,6'h19,1'b0},
    '{emo_plain_subtract_to_mem,3'd0,8'h05,8'h05,6'h00,8'h00,8'h05,6'h27,1'b0},
    '{emo_nibble_exchange,3'd0,8'h3c,8'h5a,6'h2a,8'hc3,8'h5a,6'h2a,1'b0},
    '{emo_nibble_exchange_to_w,3'd0,8'ha5,8'h11,6'h2a,8'ha5,8'h5a,6'h2a,1'b0},
    '{emo_skip_if_null,3'd0,8'h00,8'h5a,6'h2a,8'h00,8'h5a,6'h2a,1'b1},
    '{emo_copy_skip_if_null,3'd0,8'h00,8'h77,6'h2a,8'h00,8'h00,6'h2a,1'b1},
    '{emo_skip_if_null_bit,3'd3,8'hf7,8'h5a,6'h2a,8'hf7,8'h5a,6'h2a,1'b1},
    '{emo_rotl_mem,3'd0,8'h81,8'h5a,6'h2a,8'h03,8'h5a,6'h2a,1'b0}
  };

  // Design under test; clock enable and strobes held on
  emo_exec DUT (.clk_sys_in, .reset_in, .clk_en_in(1'b1), .req_valid_in, .req_op_in,
    .req_bit_in, .req_addr_in, .busy_out, .done_out, .skip_out, .mem_addr_out,
    .mem_rd_out, .mem_rdata_in, .mem_we_out, .mem_wdata_out, .working_register_out,
    .flags_out, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pstrb_in(4'hf), .pready_out, .prdata_out, .pslverr_out);

  // Data memory behind the datapath
  emo_mem_model u_mem (.clk_sys_in, .mem_addr_in(mem_addr_out), .mem_rd_in(mem_rd_out),
    .mem_we_in(mem_we_out), .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in));

  // 100 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Compare one value and count it
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; waits for ready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel_in    <= 1'b1;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= wd;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 20);
    rd = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  // Preset state, issue one operation and compare the end state
  task automatic run_case(input emo_case_type c, input logic [15:0] a);
    int   n;
    logic sk;
    n  = 0;
    sk = 1'b0;
    u_mem.mem[a] = c.m;
    apb(1'b1, EMO_OFS_WREG, {24'h0, c.w});
    apb(1'b1, EMO_OFS_FLAGS, {26'h0, c.f0});
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_op_in    <= c.op;
    req_bit_in   <= c.b;
    req_addr_in  <= a;
    do
    begin
      @(posedge clk_sys_in);
      req_valid_in <= 1'b0;
      #1;
      n++;
      if (skip_out === 1'b1)
        sk = 1'b1;
    end
    while (done_out !== 1'b1 && n < 8);
    if (done_out !== 1'b1)
    begin
      error_cnt++;
      complete_run();
    end
    // Memory takes the write one edge after the result
    @(posedge clk_sys_in);
    #1;
    check("cycles", 32'(2 + c.sk), 32'(n));
    check("skip", {31'h0, c.sk}, {31'h0, sk});
    check("working register", {24'h0, c.ew}, {24'h0, working_register_out});
    check("flags", {26'h0, c.ef}, {26'h0, flags_out});
    check("memory", {24'h0, c.em}, {24'h0, u_mem.mem[a]});
  endtask

  // Main sequence
  initial
  begin
    error_cnt    = 0;
    compares     = 0;
    reset_in     = 1'b1;
    req_valid_in = 1'b0;
    req_op_in    = emo_rotl_mem;
    req_bit_in   = 3'h0;
    req_addr_in  = 16'h0000;
    psel_in      = 1'b0;
    penable_in   = 1'b0;
    pwrite_in    = 1'b0;
    paddr_in     = 8'h00;
    pwdata_in    = 32'h0;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    apb(1'b0, EMO_OFS_WREG, 32'h0);
    check("wreg reset", {24'h0, EMO_WREG_RST}, rd);
    apb(1'b0, EMO_OFS_FLAGS, 32'h0);
    check("flags reset", {26'h0, EMO_FLAGS_RST}, rd);
    apb(1'b1, EMO_OFS_STATUS, 32'h3);
    check("status write error", 32'h1, {31'h0, err});
    apb(1'b1, 8'h0c, 32'hff);
    check("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, EMO_OFS_WREG, 32'h1234_56a5);
    apb(1'b0, EMO_OFS_WREG, 32'h0);
    check("wreg readback", 32'h0000_00a5, rd);
    $display("test registers done");
    foreach (cases[i])
      run_case(cases[i], 16'(i * 16'h0925 + 16'h0010));
    $display("test operations done");
    complete_run();
  end

endmodule

bind emo_exec emo_exec_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_sys_in, .reset_in, .req_valid_in,
  .req_op_in, .req_addr_in, .busy_out, .done_out, .skip_out, .mem_addr_out, .mem_rd_out,
  .mem_rdata_in, .mem_we_out, .mem_wdata_out, .flags_out, .psel_in, .penable_in,
  .pready_out);
